// File: pwc_wiper_ctrl.sv
// Purpose: Volatile 7-bit wiper register with its serial slave and supply trip control
// Assumes: SCL is also the link clock; brown-out flag comes from an analog comparator
// Notes:   Functional notes follow
// Functional notes
// - Wiper presets to 3Fh when the supply trip reset releases.
// - During brown-out the serial port is off, never acks, never drives data.
// - Code 0x00 selects the zero-scale tap at the low terminal.
// - Code 0x7F selects the full-scale tap at the high terminal.
// - Stop enters static serial-inactive state; Start makes it serial-active.
// - Slave only; the master supplies every serial clock pulse.
// - Data driven only low via open drain; input sampled through hysteresis stage.
// - Above the trip level reads and writes work; stored value sets wiper.
// - Start is data falling with clock high; Stop is data rising.
// - Clock line is never held low; accesses finish within master timing.

`timescale 1ns/100ps

module pwc_wiper_ctrl #(
    parameter logic [6:0] SLAVE_ADDR = pwc_pkg::SLAVE_ADDR_DEFAULT
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Supply monitor
    input wire logic brown_out_reset,
    // Serial clock pin, also the link clock
    input wire logic scl_clk,
    output pwc_pkg::pwc_od_t scl_drive,
    // Serial data pin
    input wire logic sda_in,
    output pwc_pkg::pwc_od_t sda_drive,
    // Wiper and status
    output pwc_pkg::pwc_tap_t wiper_tap,
    output logic serial_active
);
    // ============================================================
    // Link domain: data bit captured on each clock rise
    logic link_bit;

    always_ff @(posedge scl_clk) begin
        link_bit <= sda_in;
    end

    // ============================================================
    // Pin synchronisers
    logic scl_f;
    logic sda_f;
    logic bor_f;

    pwc_sync3 #(.RST_VAL(1'b1)) u_sync_scl (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(scl_clk),
        .dout(scl_f)
    );

    pwc_sync3 #(.RST_VAL(1'b1)) u_sync_sda (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(sda_in),
        .dout(sda_f)
    );

    pwc_sync3 #(.RST_VAL(1'b0)) u_sync_bor (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(brown_out_reset),
        .dout(bor_f)
    );

    // ============================================================
    // Bus condition detection
    logic scl_q;
    logic sda_q;
    logic bor_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic bor_release;

    assign scl_rise = scl_f && !scl_q;
    assign scl_fall = !scl_f && scl_q;
    assign start_seen = scl_f && scl_q && sda_q && !sda_f;
    assign stop_seen = scl_f && scl_q && !sda_q && sda_f;
    assign bor_release = bor_q && !bor_f;

    // ============================================================
    // Serial state machine and wiper register
    pwc_pkg::pwc_state_t state;
    pwc_pkg::pwc_state_t next_state;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic rd_mode;
    logic next_rd_mode;
    logic sda_oe;
    logic next_sda_oe;
    logic [6:0] wiper;
    logic [6:0] next_wiper;
    logic active;
    logic next_active;
    pwc_pkg::pwc_tap_t next_tap;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_rd_mode = rd_mode;
        next_sda_oe = sda_oe;
        next_wiper = wiper;
        next_active = active;
        if (bor_f) begin
            next_state = pwc_pkg::PWC_STATIC;
            next_sda_oe = 1'b0;
            next_active = 1'b0;
        end else if (bor_release) begin
            next_wiper = pwc_pkg::WIPER_DEFAULT;
            next_state = pwc_pkg::PWC_STATIC;
            next_sda_oe = 1'b0;
            next_active = 1'b0;
        end else if (start_seen) begin
            next_state = pwc_pkg::PWC_ADDR;
            next_active = 1'b1;
            next_bit_cnt = pwc_pkg::BIT_FIRST;
            next_sda_oe = 1'b0;
        end else if (stop_seen) begin
            next_state = pwc_pkg::PWC_STATIC;
            next_active = 1'b0;
            next_sda_oe = 1'b0;
        end else begin
            unique case (state)
                pwc_pkg::PWC_STATIC, pwc_pkg::PWC_IGNORE: begin
                    next_sda_oe = 1'b0;
                end
                pwc_pkg::PWC_ADDR, pwc_pkg::PWC_RX: begin
                    if (scl_rise) begin
                        // Bit value held stable in the link domain since this rise
                        next_shreg = {shreg[6:0], link_bit};
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == pwc_pkg::BIT_LAST) begin
                            next_state = (state == pwc_pkg::PWC_ADDR) ? pwc_pkg::PWC_ADDR_ACK
                                : pwc_pkg::PWC_RX_ACK;
                        end
                    end
                end
                pwc_pkg::PWC_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (shreg[7:1] == SLAVE_ADDR && shreg[7:1] != pwc_pkg::GENERAL_CALL) begin
                            next_sda_oe = 1'b1;
                            next_rd_mode = shreg[0];
                            next_state = pwc_pkg::PWC_ACK_HOLD;
                        end else begin
                            next_state = pwc_pkg::PWC_IGNORE;
                        end
                    end
                end
                pwc_pkg::PWC_RX_ACK: begin
                    if (scl_fall) begin
                        next_wiper = shreg[6:0];
                        next_sda_oe = 1'b1;
                        next_state = pwc_pkg::PWC_ACK_HOLD;
                    end
                end
                pwc_pkg::PWC_ACK_HOLD: begin
                    if (scl_fall) begin
                        next_bit_cnt = pwc_pkg::BIT_FIRST;
                        if (rd_mode) begin
                            next_shreg = {1'b0, wiper};
                            next_sda_oe = 1'b1;
                            next_state = pwc_pkg::PWC_TX;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state = pwc_pkg::PWC_RX;
                        end
                    end
                end
                pwc_pkg::PWC_TX: begin
                    if (scl_fall) begin
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == pwc_pkg::BIT_LAST) begin
                            next_sda_oe = 1'b0;
                            next_state = pwc_pkg::PWC_TX_ACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_sda_oe = !shreg[6];
                        end
                    end
                end
                pwc_pkg::PWC_TX_ACK: begin
                    if (scl_rise) begin
                        next_state = link_bit ? pwc_pkg::PWC_IGNORE : pwc_pkg::PWC_ACK_HOLD;
                    end
                end
            endcase
        end
        next_tap.code = wiper;
        next_tap.at_zero = (wiper == pwc_pkg::TAP_ZERO);
        next_tap.at_full = (wiper == pwc_pkg::TAP_FULL);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bor_q <= 1'b0;
            state <= pwc_pkg::PWC_STATIC;
            bit_cnt <= pwc_pkg::BIT_FIRST;
            shreg <= 8'h00;
            rd_mode <= 1'b0;
            sda_oe <= 1'b0;
            wiper <= pwc_pkg::WIPER_DEFAULT;
            active <= 1'b0;
            wiper_tap <= '{code: pwc_pkg::WIPER_DEFAULT, at_zero: 1'b0, at_full: 1'b0};
            sda_drive <= '{oe: 1'b0, out: 1'b0};
            scl_drive <= '{oe: 1'b0, out: 1'b0};
            serial_active <= 1'b0;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
            bor_q <= bor_f;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            rd_mode <= next_rd_mode;
            sda_oe <= next_sda_oe;
            wiper <= next_wiper;
            active <= next_active;
            wiper_tap <= next_tap;
            sda_drive <= '{oe: next_sda_oe && !bor_f, out: 1'b0};
            scl_drive <= '{oe: 1'b0, out: 1'b0};
            serial_active <= next_active;
        end
    end
endmodule // pwc_wiper_ctrl

// File: pwc_sync3.sv
// Purpose: Shared constants and types, plus a three-stage pin synchroniser with an agreement filter
// Assumes: Inputs arrive asynchronously to core_clk
// Notes:   The filtered level changes only when stages two and three agree

// ============================================================
// Package
package pwc_pkg;
    localparam int WIPER_W = 7;
    localparam logic [6:0] WIPER_DEFAULT = 7'h3F;
    localparam logic [6:0] TAP_ZERO = 7'h00;
    localparam logic [6:0] TAP_FULL = 7'h7F;
    localparam logic [6:0] GENERAL_CALL = 7'h00;
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2E;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    typedef enum logic [3:0] {
        PWC_STATIC,
        PWC_ADDR,
        PWC_ADDR_ACK,
        PWC_ACK_HOLD,
        PWC_RX,
        PWC_RX_ACK,
        PWC_TX,
        PWC_TX_ACK,
        PWC_IGNORE
    } pwc_state_t;

    typedef struct packed {
        logic [6:0] code;
        logic at_zero;
        logic at_full;
    } pwc_tap_t;

    typedef struct packed {
        logic oe;
        logic out;
    } pwc_od_t;
endpackage

`timescale 1ns/100ps

// ============================================================
// Three-stage synchroniser
module pwc_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Asynchronous level in, filtered level out
    input wire logic din,
    output logic dout
);
    logic s1;
    logic s2;
    logic s3;
    logic next_dout;

    always_comb begin
        next_dout = dout;
        if (s2 == s3) begin
            next_dout = s3;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end
endmodule // pwc_sync3

// File: pwc_wiper_ctrl_assertions.sv
// Purpose: Port checks for the wiper controller
// Assumes: Bus levels are seen at the pins
// Notes: Bound to every instance
`timescale 1ns/100ps
module pwc_wiper_ctrl_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Supply and bus pins
    input wire logic brown_out_reset,
    input wire logic scl_clk,
    input wire logic sda_in,
    input pwc_pkg::pwc_od_t scl_drive,
    input pwc_pkg::pwc_od_t sda_drive,
    // Wiper and status
    input pwc_pkg::pwc_tap_t wiper_tap,
    input wire logic serial_active
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence bus_start;
        scl_clk && $past(scl_clk) && $fell(sda_in);
    endsequence
    sequence bus_stop;
        scl_clk && $past(scl_clk) && $rose(sda_in);
    endsequence
    sequence supply_ok;
        !brown_out_reset [*8];
    endsequence
    AST_SCL_FREE: assert property (scl_drive.oe == 1'h0) else $error("scl driven");
    AST_SDA_LOW: assert property (sda_drive.oe |-> sda_drive.out == 1'h0) else $error("sda high");
    AST_BOR_QUIET: assert property (brown_out_reset [*8] |-> !sda_drive.oe && !serial_active)
        else $error("bus on in brown-out");
    AST_BOR_PRESET: assert property (brown_out_reset ##1 supply_ok |-> wiper_tap.code == 7'h3F)
        else $error("no preset");
    AST_RST_PRESET: assert property ($rose(rst_n) |-> wiper_tap.code == 7'h3F) else $error("bad reset");
    AST_ZERO: assert property (wiper_tap.at_zero == (wiper_tap.code == 7'h00)) else $error("zero flag");
    AST_FULL: assert property (wiper_tap.at_full == (wiper_tap.code == 7'h7F)) else $error("full flag");
    AST_START: assert property (supply_ok ##0 bus_start |-> ##[1:8] serial_active)
        else $error("start missed");
    AST_STOP: assert property (bus_stop |-> ##[1:8] !serial_active) else $error("stop missed");
endmodule // pwc_wiper_ctrl_assertions
bind pwc_wiper_ctrl pwc_wiper_ctrl_assertions u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .brown_out_reset(brown_out_reset),
    .scl_clk(scl_clk), .sda_in(sda_in), .scl_drive(scl_drive), .sda_drive(sda_drive),
    .wiper_tap(wiper_tap), .serial_active(serial_active));

// File: pwc_i2c_master.sv
// Purpose: Bus master model for the serial pins
// Assumes: Pull-ups on both wires
// Notes: Clock stands high between frames
`timescale 1ns/100ps
module pwc_i2c_master (
    // Link clock and resolved data wire
    input wire logic lclk,
    input wire logic sda,
    // Pin levels, high means released
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge lclk);
        #1;
    endtask
    // Data changes 8 ticks into the 12-tick low, sampled mid-high
    task automatic bit_x(input logic b, output logic r);
        scl_o = 1'h0;
        tk(8);
        sda_o = b;
        tk(4);
        scl_o = 1'h1;
        tk(6);
        r = sda;
        tk(6);
    endtask
    task automatic start();
        tk(6);
        sda_o = 1'h0;
        tk(6);
    endtask
    task automatic stop();
        bit_x(1'h0, sda_o);
        sda_o = 1'h1;
        tk(6);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ak_in, output logic [7:0] q, output logic ak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(ak_in, r);
        ak = ~r;
    endtask
endmodule // pwc_i2c_master

// File: pwc_wiper_ctrl_test.sv
// Purpose: Self-checking bench for the wiper controller
// Assumes: Master model on its own clock
// Notes: Random data from a shift register seeded 87
`timescale 1ns/100ps
module pwc_wiper_ctrl_test;
    localparam logic [6:0] own_adr = pwc_pkg::SLAVE_ADDR_DEFAULT;
    logic core_clk = 1'h0;
    logic lclk = 1'h0;
    logic rst_n = 1'h0;
    logic brown_out_reset = 1'h0;
    logic m_scl, m_sda, scl, sda, serial_active, ak;
    pwc_pkg::pwc_od_t scl_drive, sda_drive;
    pwc_pkg::pwc_tap_t wiper_tap;
    logic [7:0] s, d, q;
    int err_total = 0;
    int n_checks = 0;
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #4;
        forever #7.5 lclk = ~lclk;
    end
    // Open-drain wires with pull-ups
    assign scl = m_scl & ~scl_drive.oe;
    assign sda = m_sda & ~sda_drive.oe;
    pwc_wiper_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .brown_out_reset(brown_out_reset),
        .scl_clk(scl), .scl_drive(scl_drive), .sda_in(sda), .sda_drive(sda_drive),
        .wiper_tap(wiper_tap), .serial_active(serial_active));
    pwc_i2c_master mst (.lclk(lclk), .sda(sda), .scl_o(m_scl), .sda_o(m_sda));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [8:0] tap_of(input logic [6:0] c);
        return {c, c == pwc_pkg::TAP_ZERO, c == pwc_pkg::TAP_FULL};
    endfunction
    task automatic end_sim;
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk_v(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // One frame: address, one data byte, stop
    task automatic access(input logic [6:0] a, input logic rd, input logic [7:0] wd);
        logic a2;
        mst.start();
        mst.xfer({a, rd}, 1'h1, q, ak);
        chk_v({8'h00, serial_active}, {8'h00, ~brown_out_reset});
        mst.xfer(rd ? 8'hFF : wd, 1'h1, q, a2);
        mst.stop();
        cyc(10);
    endtask
    initial begin
        cyc(12);
        rst_n = 1'h1;
        cyc(6);
        chk_v(wiper_tap, tap_of(pwc_pkg::WIPER_DEFAULT));
        s = 8'h57;
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : s;
            s = lfsr(s);
            access(own_adr, 1'h0, d);
            chk_v({8'h00, ak}, 9'h001);
            chk_v(wiper_tap, tap_of(d[6:0]));
            chk_v({8'h00, serial_active}, 9'h000);
            access(own_adr, 1'h1, 8'h00);
            chk_v({1'h0, q}, {2'h0, d[6:0]});
        end
        for (int k = 0; k < 2; k++) begin
            access(k ? pwc_pkg::GENERAL_CALL : own_adr ^ 7'h01, 1'h0, 8'h11);
            chk_v({8'h00, ak}, 9'h000);
            chk_v(wiper_tap, tap_of(d[6:0]));
        end
        brown_out_reset = 1'h1;
        cyc(10);
        access(own_adr, 1'h0, 8'h11);
        chk_v({8'h00, ak}, 9'h000);
        brown_out_reset = 1'h0;
        cyc(10);
        chk_v(wiper_tap, tap_of(pwc_pkg::WIPER_DEFAULT));
        access(own_adr, 1'h0, 8'h2A);
        chk_v(wiper_tap, tap_of(7'h2A));
        rst_n = 1'h0;
        cyc(4);
        rst_n = 1'h1;
        cyc(6);
        chk_v(wiper_tap, tap_of(pwc_pkg::WIPER_DEFAULT));
        end_sim();
    end
endmodule // pwc_wiper_ctrl_test
